//--- design/cdr_cfg_regs.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Recovery configuration and status bank behind a 16-bit serial port.
// ----------------------------------------------------------------
module cdr_cfg_regs (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	input wire logic soft_rst_req,
	input wire logic [cdr_cfg_pkg::DATA_W-1:0] bit_time_meas,
	input wire logic bit_time_meas_valid,
	input wire logic [cdr_cfg_pkg::WD_W-1:0] watchdog_failure_counter,
	output logic [1:0] recovery_clock_select_field,
	output logic [3:0] recovery_clk_onehot,
	output logic [cdr_cfg_pkg::DATA_W-1:0] upper_bit_time_limit,
	output logic [cdr_cfg_pkg::DATA_W-1:0] lower_bit_time_limit,
	output logic [cdr_cfg_pkg::DATA_W-1:0] bit_time_clamped,
	output logic bit_time_clamped_valid
);
	import cdr_cfg_pkg::*;

	// ----------------------------------------------------------------
	// Decoding helpers.
	// ----------------------------------------------------------------

	// Turns the select code into a one-hot recovery clock choice.
	function automatic logic [3:0] clk_onehot(input logic [1:0] code);
		logic [3:0] oh;
		oh = 4'h0;
		case (code)
			SEL_80MHZ: oh = 4'h1;
			SEL_40MHZ: oh = 4'h2;
			SEL_20MHZ: oh = 4'h4;
			default: oh = 4'h8;
		endcase
		return oh;
	endfunction : clk_onehot

	// ----------------------------------------------------------------
	// Reset release for the system clock domain.
	// ----------------------------------------------------------------
	logic rst_s1_q; // First reset release stage.
	logic rst_sync_n; // Released copy used by the whole clk domain.

	// Reset asserts at once and releases two edges later.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_sync_n <= rst_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Link domain: serial shifter clocked by the host clock.
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] bit_cnt_q; // Bits received in the current frame.
	logic [FRAME_BITS-1:0] shift_q; // Frame assembly buffer.
	logic [FRAME_BITS-1:0] word_q; // Last complete frame, held until the next one.
	logic frame_tgl_q; // Flips once per complete frame.
	logic [FRAME_BITS-1:0] resp_q; // Answer word, written in the clk domain.

	// The counter restarts whenever chip select is high; short frames
	// therefore never reach the command stage.
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_q <= '0;
		end else if (bit_cnt_q != CNT_W'(FRAME_BITS)) begin
			bit_cnt_q <= bit_cnt_q + CNT_W'(1);
		end
	end

	// Bits arrive first-bit-first; bit 0 lands at index 0.
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			shift_q <= '0;
		end else if (bit_cnt_q < CNT_W'(FRAME_BITS)) begin
			shift_q[bit_cnt_q[3:0]] <= mosi;
		end
	end

	// Only a full sixteenth bit completes a command; extra bits are dropped.
	always_ff @(posedge sclk or negedge rst_n) begin
		if (!rst_n) begin
			word_q <= '0;
			frame_tgl_q <= 1'b0;
		end else if (!cs_n && bit_cnt_q == CNT_W'(FRAME_BITS - 1)) begin
			word_q <= {mosi, shift_q[FRAME_BITS-2:0]};
			frame_tgl_q <= ~frame_tgl_q;
		end
	end

	// The answer is driven on the falling edge. Bit 0 is the idle level
	// forced by chip select, so the answer word keeps its bit 0 at zero.
	// The answer word is only read while the host keeps frames apart, so
	// it is quiet by the time a new frame shifts it out.
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			miso <= 1'b0;
		end else if (bit_cnt_q < CNT_W'(FRAME_BITS)) begin
			miso <= resp_q[bit_cnt_q[3:0]];
		end else begin
			miso <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Frame event crossing into the clk domain.
	// ----------------------------------------------------------------
	logic tgl_s1_q; // First synchroniser stage, read only by the second.
	logic tgl_s2_q; // Second synchroniser stage.
	logic tgl_s3_q; // Delayed copy for edge detection.
	logic frame_evt; // One-cycle pulse per received frame.

	// A toggle carries the event; the word itself stays still meanwhile.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			tgl_s1_q <= 1'b0;
			tgl_s2_q <= 1'b0;
			tgl_s3_q <= 1'b0;
		end else begin
			tgl_s1_q <= frame_tgl_q;
			tgl_s2_q <= tgl_s1_q;
			tgl_s3_q <= tgl_s2_q;
		end
	end

	assign frame_evt = tgl_s2_q ^ tgl_s3_q;

	// ----------------------------------------------------------------
	// Command decode.
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] cmd_addr; // Register address of the frame.
	logic cmd_mode; // High writes a control register or clears a status one.
	logic [DATA_W-1:0] cmd_data; // Data byte of the frame.
	logic wr_sel; // Write to the clock select register.
	logic wr_upper; // Write to the upper limit register.
	logic wr_lower; // Write to the lower limit register.
	logic clr_status; // Clear command on the status register.

	assign cmd_addr = word_q[ADDR_W-1:0];
	assign cmd_mode = word_q[MODE_BIT];
	assign cmd_data = word_q[DATA_LSB +: DATA_W];

	// Each address names one whole byte; no partial or bit access exists.
	always_comb begin
		wr_sel = 1'b0;
		wr_upper = 1'b0;
		wr_lower = 1'b0;
		clr_status = 1'b0;
		if (frame_evt && cmd_mode && cmd_addr == ADDR_CLK_SEL) begin
			wr_sel = 1'b1;
		end else if (frame_evt && cmd_mode && cmd_addr == ADDR_UPPER) begin
			wr_upper = 1'b1;
		end else if (frame_evt && cmd_mode && cmd_addr == ADDR_LOWER) begin
			wr_lower = 1'b1;
		end else if (frame_evt && cmd_mode && cmd_addr == ADDR_STATUS) begin
			clr_status = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers.
	// ----------------------------------------------------------------

	// Only two bits are stored, so the reserved upper bits cannot be
	// anything but zero. A soft reset request returns it to the reset code.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			recovery_clock_select_field <= CLK_SEL_RST;
		end else if (soft_rst_req) begin
			recovery_clock_select_field <= CLK_SEL_RST;
		end else if (wr_sel) begin
			recovery_clock_select_field <= cmd_data[SEL_LSB +: SEL_W];
		end
	end

	// The one-hot choice follows the stored code one cycle later.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			recovery_clk_onehot <= 4'h1;
		end else begin
			recovery_clk_onehot <= clk_onehot(recovery_clock_select_field);
		end
	end

	// Upper limit register.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			upper_bit_time_limit <= UPPER_RST;
		end else if (soft_rst_req) begin
			upper_bit_time_limit <= UPPER_RST;
		end else if (wr_upper) begin
			upper_bit_time_limit <= cmd_data;
		end
	end

	// Lower limit register.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			lower_bit_time_limit <= LOWER_RST;
		end else if (soft_rst_req) begin
			lower_bit_time_limit <= LOWER_RST;
		end else if (wr_lower) begin
			lower_bit_time_limit <= cmd_data;
		end
	end

	// ----------------------------------------------------------------
	// Bit-time clamp.
	// ----------------------------------------------------------------
	logic clamp_hi; // Measurement above the upper limit.
	logic clamp_lo; // Measurement below the lower limit.

	// Limits are not checked against each other; a host that programs
	// lower above upper gets the upper clamp first.
	assign clamp_hi = bit_time_meas_valid && (bit_time_meas > upper_bit_time_limit);
	assign clamp_lo = bit_time_meas_valid && !clamp_hi && (bit_time_meas < lower_bit_time_limit);

	// Clamped value and its valid strobe, one cycle after the measurement.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			bit_time_clamped <= '0;
			bit_time_clamped_valid <= 1'b0;
		end else begin
			bit_time_clamped_valid <= bit_time_meas_valid;
			if (clamp_hi) begin
				bit_time_clamped <= upper_bit_time_limit;
			end else if (clamp_lo) begin
				bit_time_clamped <= lower_bit_time_limit;
			end else if (bit_time_meas_valid) begin
				bit_time_clamped <= bit_time_meas;
			end
		end
	end

	// ----------------------------------------------------------------
	// Status register.
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] status_q; // Clamp flags and watchdog failure count.

	// Clamp flags are sticky; a clear in the same cycle as a new clamp
	// loses, so no event is missed. The data byte plays no part here.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			status_q <= STATUS_RST;
		end else if (soft_rst_req) begin
			status_q <= STATUS_RST;
		end else begin
			if (clamp_hi) begin
				status_q[ST_CLAMP_HI] <= 1'b1;
			end else if (clr_status) begin
				status_q[ST_CLAMP_HI] <= 1'b0;
			end
			if (clamp_lo) begin
				status_q[ST_CLAMP_LO] <= 1'b1;
			end else if (clr_status) begin
				status_q[ST_CLAMP_LO] <= 1'b0;
			end
			status_q[ST_WD_LSB +: WD_W] <= watchdog_failure_counter;
		end
	end

	// ----------------------------------------------------------------
	// Answer word.
	// ----------------------------------------------------------------

	// Readback byte of an address; unmapped addresses read zero.
	function automatic logic [7:0] read_byte(input logic [6:0] a, input logic [1:0] sel,
		input logic [7:0] up, input logic [7:0] lo, input logic [7:0] st, input logic [7:0] bt);
		logic [7:0] v;
		v = 8'h00;
		if (a == ADDR_CLK_SEL) begin
			v = {6'h00, sel};
		end else if (a == ADDR_UPPER) begin
			v = up;
		end else if (a == ADDR_LOWER) begin
			v = lo;
		end else if (a == ADDR_STATUS) begin
			v = st;
		end else if (a == ADDR_BIT_TIME) begin
			v = bt;
		end
		return v;
	endfunction : read_byte

	// The answer echoes the address and carries the contents seen just
	// before the command acted, so a clear returns what it cleared.
	// It goes out during the following frame.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			resp_q <= '0;
		end else if (frame_evt) begin
			resp_q <= {read_byte(cmd_addr, recovery_clock_select_field, upper_bit_time_limit,
				lower_bit_time_limit, status_q, bit_time_clamped), cmd_addr, 1'b0};
		end
	end

	// ----------------------------------------------------------------
	// Checks.
	// ----------------------------------------------------------------
	logic status_read; // Side-effect-free read of the status register.

	assign status_read = frame_evt && !cmd_mode && cmd_addr == ADDR_STATUS;

	AST_SEL_WRITE: assert property (@(posedge clk) disable iff (!rst_sync_n)
		wr_sel && !soft_rst_req |=> recovery_clock_select_field == $past(cmd_data[1:0]))
		else $error("Clock select write not stored.");

	AST_ONEHOT_40: assert property (@(posedge clk) disable iff (!rst_sync_n)
		recovery_clock_select_field == SEL_40MHZ ##1 recovery_clock_select_field == SEL_40MHZ
		|-> recovery_clk_onehot == 4'h2)
		else $error("Select code 01 does not pick the 40 MHz clock.");

	AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_sync_n)
		frame_evt && cmd_addr == ADDR_CLK_SEL |=> resp_q[15:10] == 6'h00)
		else $error("Reserved select bits read nonzero.");

	AST_SOFT_RESET: assert property (@(posedge clk) disable iff (!rst_sync_n)
		soft_rst_req |=> upper_bit_time_limit == 8'ha8 && lower_bit_time_limit == 8'h98
		&& recovery_clock_select_field == 2'h0)
		else $error("Soft reset values wrong.");

	AST_CLAMP_HIGH: assert property (@(posedge clk) disable iff (!rst_sync_n)
		clamp_hi && !soft_rst_req |=> bit_time_clamped == $past(upper_bit_time_limit) && status_q[0]
		&& bit_time_clamped_valid)
		else $error("High bit time not clamped to upper limit.");

	AST_CLAMP_LOW: assert property (@(posedge clk) disable iff (!rst_sync_n)
		clamp_lo && !soft_rst_req |=> bit_time_clamped == $past(lower_bit_time_limit) && status_q[1])
		else $error("Low bit time not clamped to lower limit.");

	AST_READ_NO_EFFECT: assert property (@(posedge clk) disable iff (!rst_sync_n)
		status_read && !bit_time_meas_valid && !soft_rst_req |=> status_q[1:0] == $past(status_q[1:0]))
		else $error("Status read changed status bits.");

	AST_CLEAR_PRIOR: assert property (@(posedge clk) disable iff (!rst_sync_n)
		clr_status && !soft_rst_req |=> resp_q[15:8] == $past(status_q)
		&& (status_q[1:0] == 2'b00 || $past(bit_time_meas_valid)))
		else $error("Clear did not return prior contents or clear flags.");

	AST_STICKY: assert property (@(posedge clk) disable iff (!rst_sync_n)
		status_q[0] && !clr_status && !soft_rst_req |=> status_q[0])
		else $error("Sticky clamp flag dropped without a clear.");

	AST_WD_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_sync_n)
		!soft_rst_req |=> status_q[7:6] == $past(watchdog_failure_counter))
		else $error("Watchdog failure count not tracked.");

	// The low byte of every answer names the command it belongs to.
	AST_RESP_ECHO: assert property (@(posedge clk) disable iff (!rst_sync_n)
		frame_evt |=> resp_q[7:0] == {$past(cmd_addr), 1'b0})
		else $error("Answer does not echo the command address.");

	// A read of any register must leave the configuration untouched.
	AST_READ_KEEPS_CFG: assert property (@(posedge clk) disable iff (!rst_sync_n)
		frame_evt && !cmd_mode && !soft_rst_req |=> $stable(recovery_clock_select_field)
		&& $stable(upper_bit_time_limit) && $stable(lower_bit_time_limit))
		else $error("Read command changed a configuration register.");

	COV_SEL_WRITE: cover property (@(posedge clk) disable iff (!rst_sync_n) wr_sel ##1 !frame_evt);
	COV_CLAMP_HIGH: cover property (@(posedge clk) disable iff (!rst_sync_n) clamp_hi);
	COV_CLEAR_SET: cover property (@(posedge clk) disable iff (!rst_sync_n) status_q[0] ##[1:50] clr_status);
	COV_CLEAR_RACE: cover property (@(posedge clk) disable iff (!rst_sync_n) clr_status && clamp_hi);

endmodule : cdr_cfg_regs

`default_nettype wire

//--- design/cdr_cfg_pkg.sv
// Functional notes
// - Select code picks 80/40/20/10 MHz recovery clock.
// - Select field is bits 1:0, read-write.
// - Select register bits 7:2 read zero.
// - Select register clears on power-on/soft reset.
// - Bit times above upper limit clamp to it.
// - Bit times below lower limit clamp to it.
// - Upper limit resets to 0xa8, survives restart; the code reloads 0xa8 on a soft reset request.
// - Lower limit resets to 0x98, survives restart; the code reloads 0x98 on a soft reset request.
// - Frame is sixteen bits: address byte, data byte.
// - First byte: seven-bit address plus mode bit.
// - Data byte ignored on status register access.
// - Register bits D0..D7 are frame bits 8..15.
// - Frame bit 7 low reads without side effects.
// - Frame bit 7 high clears clearable status bits.
// - Status bits sticky except watchdog failure counter.
// - Read/clear bits readable and clearable by command.
// - Read/hardware bits may change by hardware anytime.
// - Each address selects one whole eight-bit register.

// ----------------------------------------------------------------
// Shared constants of the recovery configuration register bank.
// ----------------------------------------------------------------
package cdr_cfg_pkg;
	// Frame layout.
	localparam int FRAME_BITS = 16;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int MODE_BIT = 7;
	localparam int DATA_LSB = 8;
	localparam int CNT_W = 5;
	// Register addresses.
	localparam logic [6:0] ADDR_CLK_SEL = 7'h3d;
	localparam logic [6:0] ADDR_UPPER = 7'h3e;
	localparam logic [6:0] ADDR_LOWER = 7'h3f;
	localparam logic [6:0] ADDR_STATUS = 7'h40;
	localparam logic [6:0] ADDR_BIT_TIME = 7'h41;
	// Reset values.
	localparam logic [1:0] CLK_SEL_RST = 2'h0;
	localparam logic [7:0] UPPER_RST = 8'ha8;
	localparam logic [7:0] LOWER_RST = 8'h98;
	localparam logic [7:0] STATUS_RST = 8'h00;
	// Field positions.
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 2;
	localparam int ST_CLAMP_HI = 0;
	localparam int ST_CLAMP_LO = 1;
	localparam int ST_WD_LSB = 6;
	localparam int WD_W = 2;
	localparam logic [7:0] STATUS_RC_MASK = 8'h03;
	// Recovery clock select codes.
	localparam logic [1:0] SEL_80MHZ = 2'h0;
	localparam logic [1:0] SEL_40MHZ = 2'h1;
	localparam logic [1:0] SEL_20MHZ = 2'h2;
	localparam logic [1:0] SEL_10MHZ = 2'h3;
endpackage : cdr_cfg_pkg

//--- verif/host_spi_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Host serial master that frames commands for the register bank.
// ----------------------------------------------------------------
module host_spi_model #(
	parameter int HALF_NS = 32, // Half period of the 64 ns link clock.
	parameter int GAP_NS = 200 // Idle time between frames, well above the settle time.
) (
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	// The link clock idles low and stands still between frames.
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end

	// Sends nbits of a frame, frame bit 0 first, and gathers one answer bit per rising edge.
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		cs_n = 1'b0;
		for (int k = 0; k < nbits; k++) begin
			// The mode bit rides in frame bit 7, the data byte in bits 15 down to 8.
			mosi = tx[k];
			#(HALF_NS);
			rx[k] = miso;
			sclk = 1'b1;
			#(HALF_NS);
			sclk = 1'b0;
		end
		#(HALF_NS);
		cs_n = 1'b1;
		// A released data line must not show a stale bit, so it flips.
		mosi = ~mosi;
		#(GAP_NS);
	endtask : xfer
endmodule : host_spi_model

`default_nettype wire

//--- verif/wake_recovery_config_and_status_access_tb.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Self-checking bench for the recovery configuration bank.
// ----------------------------------------------------------------
module wake_recovery_config_and_status_access_tb;
	import cdr_cfg_pkg::*;
	// One ordinary command and the prior contents its answer should carry.
	typedef struct packed {logic [6:0] a; logic m; logic [7:0] d; logic [7:0] p;} row_s;
	logic clk, rst_n, sclk, cs_n, mosi, miso, soft_rst_req, bit_time_meas_valid, bit_time_clamped_valid;
	logic [7:0] bit_time_meas, upper_bit_time_limit, lower_bit_time_limit, bit_time_clamped;
	logic [1:0] watchdog_failure_counter, recovery_clock_select_field;
	logic [3:0] recovery_clk_onehot;
	logic [15:0] rx;
	logic [6:0] prev_a;
	logic [7:0] prev_p;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	// Reads, writes with reserved bits set, an unmapped place and a status clear.
	row_s rows [0:13] = '{'{7'h3d, 1'b0, 8'hff, 8'h00}, '{7'h3d, 1'b1, 8'hff, 8'h00}, '{7'h3d, 1'b0, 8'h00, 8'h03},
		'{7'h3d, 1'b1, 8'h01, 8'h03}, '{7'h3e, 1'b0, 8'hff, 8'ha8}, '{7'h3e, 1'b1, 8'h54, 8'ha8},
		'{7'h3f, 1'b0, 8'h00, 8'h98}, '{7'h3f, 1'b1, 8'h4c, 8'h98}, '{7'h3e, 1'b0, 8'h00, 8'h54},
		'{7'h3f, 1'b0, 8'hff, 8'h4c}, '{7'h10, 1'b1, 8'h55, 8'h00}, '{7'h10, 1'b0, 8'h00, 8'h00},
		'{7'h40, 1'b1, 8'hff, 8'h00}, '{7'h3d, 1'b0, 8'h00, 8'h01}};
	// Measurements around the recommended limits and the values they should clamp to.
	logic [7:0] meas_v [0:6] = '{8'ha0, 8'hb0, 8'ha9, 8'ha8, 8'h90, 8'h97, 8'h98};
	logic [7:0] exp_v [0:6] = '{8'ha0, 8'ha8, 8'ha8, 8'ha8, 8'h98, 8'h98, 8'h98};

	cdr_cfg_regs u_cdr_cfg_regs (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
		.soft_rst_req(soft_rst_req), .bit_time_meas(bit_time_meas), .bit_time_meas_valid(bit_time_meas_valid),
		.watchdog_failure_counter(watchdog_failure_counter), .recovery_clock_select_field(recovery_clock_select_field),
		.recovery_clk_onehot(recovery_clk_onehot), .upper_bit_time_limit(upper_bit_time_limit),
		.lower_bit_time_limit(lower_bit_time_limit), .bit_time_clamped(bit_time_clamped),
		.bit_time_clamped_valid(bit_time_clamped_valid));
	host_spi_model u_host_spi_model (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

	// ----------------------------------------------------------------
	// Clock, hang guard and shared tasks.
	// ----------------------------------------------------------------
	// The system clock runs at 100 MHz.
	always #5 clk = ~clk;

	// The run takes some 3700 cycles; the ceiling leaves ample room before a hang is declared.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			$display("CHECK FAILED at %0t: run did not finish in time", $time);
			final_report();
		end
	end

	// Compares one answer word from the link.
	task automatic cmp_resp(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: answer %h expected %h", $time, got, exp);
		end
	endtask : cmp_resp

	// Compares one value seen on the block's outputs.
	task automatic cmp_port(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: output %h expected %h", $time, got, exp);
		end
	endtask : cmp_port

	// Answer word: prior contents high, address in bits 7:1, bit 0 low.
	function automatic logic [15:0] resp(input logic [6:0] a, input logic [7:0] p);
		return {p, a, 1'b0};
	endfunction : resp

	// Sends one whole command frame.
	task automatic send(input logic [6:0] a, input logic m, input logic [7:0] d);
		u_host_spi_model.xfer({d, m, a}, 16, rx);
	endtask : send

	// Checks the select field, its decoded clock and both limits.
	task automatic check_regs(input logic [1:0] s, input logic [7:0] u, input logic [7:0] l);
		cmp_port({6'h00, recovery_clock_select_field}, {6'h00, s});
		cmp_port({4'h0, recovery_clk_onehot}, 8'h01 << s);
		cmp_port(upper_bit_time_limit, u);
		cmp_port(lower_bit_time_limit, l);
	endtask : check_regs

	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// Main sequence; inputs change on the falling clock edge.
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		soft_rst_req = 1'b0;
		bit_time_meas = 8'h00;
		bit_time_meas_valid = 1'b0;
		watchdog_failure_counter = 2'h0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		check_regs(2'h0, 8'ha8, 8'h98);
		cmp_port({7'h00, miso}, 8'h00);
		$display("test reset done");
		// Each answer arrives in the frame after its command.
		for (int i = 0; i < 14; i++) begin
			send(rows[i].a, rows[i].m, rows[i].d);
			if (i > 0) cmp_resp(rx, resp(prev_a, prev_p));
			prev_a = rows[i].a;
			prev_p = rows[i].p;
		end
		check_regs(2'h1, 8'h54, 8'h4c);
		$display("test table done");
		// Every select code, with the reserved bits set in the data byte.
		for (int c = 0; c < 4; c++) begin
			send(ADDR_CLK_SEL, 1'b1, {6'h3f, 2'(c)});
			if (c == 0) cmp_resp(rx, resp(7'h3d, 8'h01));
			check_regs(2'(c), 8'h54, 8'h4c);
		end
		$display("test clock codes done");
		// A frame cut short must change nothing.
		u_host_spi_model.xfer({8'h00, 1'b1, 7'h3e}, 12, rx);
		check_regs(2'h3, 8'h54, 8'h4c);
		// Recommended limits for a recovery clock of 160 times the baud rate.
		send(ADDR_UPPER, 1'b1, 8'ha8);
		send(ADDR_LOWER, 1'b1, 8'h98);
		cmp_resp(rx, resp(7'h3e, 8'h54));
		$display("test limits done");
		// Inputs of the clk domain move only on the falling edge.
		@(negedge clk);
		watchdog_failure_counter = 2'h2;
		for (int i = 0; i < 7; i++) begin
			@(negedge clk);
			bit_time_meas = meas_v[i];
			bit_time_meas_valid = 1'b1;
			@(negedge clk);
			bit_time_meas_valid = 1'b0;
			cmp_port({7'h00, bit_time_clamped_valid}, 8'h01);
			cmp_port(bit_time_clamped, exp_v[i]);
		end
		$display("test clamp done");
		// Flags stay set, clear returns them first, the counter bits survive the clear.
		send(ADDR_STATUS, 1'b0, 8'hff);
		send(ADDR_STATUS, 1'b1, 8'h00);
		cmp_resp(rx, resp(7'h40, 8'h83));
		send(ADDR_STATUS, 1'b0, 8'h00);
		cmp_resp(rx, resp(7'h40, 8'h83));
		send(ADDR_CLK_SEL, 1'b0, 8'h00);
		cmp_resp(rx, resp(7'h40, 8'h80));
		$display("test status done");
		send(ADDR_UPPER, 1'b1, 8'h11);
		cmp_resp(rx, resp(7'h3d, 8'h03));
		// The bit-time readback ignores writes and shows the last clamped value.
		send(ADDR_BIT_TIME, 1'b1, 8'h5a);
		cmp_resp(rx, resp(7'h3e, 8'ha8));
		send(ADDR_CLK_SEL, 1'b0, 8'h00);
		cmp_resp(rx, resp(7'h41, 8'h98));
		@(negedge clk);
		soft_rst_req = 1'b1;
		@(negedge clk);
		soft_rst_req = 1'b0;
		@(negedge clk);
		check_regs(2'h0, 8'ha8, 8'h98);
		$display("test soft reset done");
		// A second reset in mid-run takes hold at once.
		send(ADDR_LOWER, 1'b1, 8'h22);
		@(negedge clk);
		rst_n = 1'b0;
		#1;
		check_regs(2'h0, 8'ha8, 8'h98);
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		check_regs(2'h0, 8'ha8, 8'h98);
		$display("test second reset done");
		final_report();
	end
endmodule : wake_recovery_config_and_status_access_tb

`default_nettype wire
